// ==== inc/chain_cfg_pkg.sv ====
// constants and types for the driver chain configuration block
package chain_cfg_pkg;

	// host datagram layout
	localparam int HOST_FRAME_BITS = 32;
	localparam int HOST_SPACE_BIT = 31;
	localparam int HOST_ADDR_MSB = 30;
	localparam int HOST_ADDR_LSB = 25;
	localparam int HOST_RW_BIT = 24;
	localparam logic [5:0] CFG_ADDR = 6'h3F;
	localparam logic [5:0] HOST_CNT_FULL = 6'h20;
	localparam logic [5:0] HOST_CNT_MAX = 6'h3F;
	localparam logic [7:0] HOST_STATUS_BYTE = 8'h00;

	// configuration register layout
	localparam int CFG_WIDTH = 24;
	localparam int CFG_COUNT_LSB = 0;
	localparam int CFG_SEL_POL = 2;
	localparam int CFG_CLK_INV = 3;
	localparam int CFG_PHASE_INV = 4;
	localparam int CFG_DECAY_POL = 5;
	localparam int CFG_CUR_INV = 6;
	localparam int CFG_PER_DRIVER = 7;
	localparam int CFG_DIV_LSB = 8;
	localparam int CFG_REFRESH = 16;
	localparam logic [23:0] CFG_USED_MASK = 24'h01FFFF;
	localparam logic [23:0] CFG_RESET = 24'h000F00;
	localparam logic [1:0] COUNT_FORBIDDEN = 2'h3;

	// chain clock divider
	localparam logic [7:0] DIV_MIN = 8'h07;

	// driver datagram layout
	localparam int DRIVERS = 3;
	localparam int DRV_WORD_BITS = 12;
	localparam logic [11:0] PHASE_MASK = 12'h840;
	localparam logic [11:0] CUR_MASK = 12'h7BC;
	localparam logic [11:0] DECAY_MASK = 12'h002;
	localparam logic [3:0] DRV_LAST_BIT = 4'hB;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE = 3'b100
	} chain_state_t;

endpackage

// ==== inc/chain_clk_if.sv ====
// bundle between the chain engine and its clock generator
`timescale 1ns/10ps
interface chain_clk_if;
	logic run;
	logic [7:0] divider;
	logic level;
	logic rise;
	logic fall;
	modport gen (input run, input divider, output level, output rise,
		output fall);
	modport user (output run, output divider, input level, input rise,
		input fall);
endinterface

// ==== verilog/chain_clock_gen.sv ====
// chain clock divider with rise and fall strobes
`timescale 1ns/10ps
module chain_clock_gen
	import chain_cfg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	chain_clk_if.gen clk_if
);

	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic level_q;
	logic level_d;
	logic rise_q;
	logic fall_q;
	logic [7:0] low_limit;
	logic [7:0] limit;
	logic wrap;

	// below the floor the low phase fills up the fastest period, so the
	// clock only loses its symmetry and never runs faster
	assign low_limit = (clk_if.divider < DIV_MIN)
		? (DIV_MIN + DIV_MIN - clk_if.divider)
		: clk_if.divider;
	assign limit = level_q ? clk_if.divider : low_limit;
	assign wrap = clk_if.run & (cnt_q >= limit);
	assign cnt_d = (!clk_if.run || wrap) ? 8'h00 : cnt_q + 8'h01;
	assign level_d = clk_if.run & (wrap ? ~level_q : level_q);

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cnt_q <= 8'h00;
			level_q <= 1'b0;
			rise_q <= 1'b0;
			fall_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			level_q <= level_d;
			rise_q <= wrap & ~level_q;
			fall_q <= wrap & level_q;
		end
	end

	assign clk_if.level = level_q;
	assign clk_if.rise = rise_q;
	assign clk_if.fall = fall_q;

endmodule

// ==== verilog/driver_chain_serial_config.sv ====
// global configuration and serial output engine of the driver chain
`timescale 1ns/10ps
module driver_chain_serial_config
	import chain_cfg_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic host_sck_in,
	input wire logic host_select_n_in,
	input wire logic host_mosi_in,
	output logic host_miso_out,
	output logic host_miso_oe_n_out,
	input wire logic send_req_in,
	input wire logic [DRIVERS*DRV_WORD_BITS-1:0] drv_word_in,
	output logic chain_clock_out,
	output logic chain_data_out,
	output logic chain_select_out,
	output logic second_driver_select_n_out,
	output logic third_driver_select_n_out,
	output logic chain_busy_out
);

	localparam int FRAME_BITS = DRIVERS * DRV_WORD_BITS;

	// host pin synchronisers
	logic [1:0] sck_sync_q;
	logic [1:0] sel_sync_q;
	logic [1:0] mosi_sync_q;
	logic sck_prev_q;
	logic sel_prev_q;

	// host datagram state
	logic [31:0] rx_q;
	logic [31:0] tx_q;
	logic [5:0] host_cnt_q;
	logic miso_oe_n_q;

	// configuration
	logic [23:0] cfg_q;
	logic [23:0] cfg_d;

	// chain engine
	chain_state_t state_q;
	chain_state_t state_d;
	logic [FRAME_BITS-1:0] shift_q;
	logic [1:0] seg_q;
	logic [3:0] bit_q;
	logic pending_q;
	logic clk_out_q;
	logic data_out_q;
	logic sel_out_q;
	logic sel2_n_q;
	logic sel3_n_q;
	logic busy_q;

	chain_clk_if clk_if ();

	chain_clock_gen u_clock_gen (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clk_if(clk_if)
	);

	// host edge decode on second synchroniser stage only
	logic sck_s;
	logic sel_n_s;
	logic mosi_s;
	logic sck_rise;
	logic sck_fall;
	logic sel_start;
	logic sel_end;
	logic sel_active;

	assign sck_s = sck_sync_q[1];
	assign sel_n_s = sel_sync_q[1];
	assign mosi_s = mosi_sync_q[1];
	assign sel_active = ~sel_n_s;
	assign sck_rise = sel_active & sck_s & ~sck_prev_q;
	assign sck_fall = sel_active & ~sck_s & sck_prev_q;
	assign sel_start = ~sel_n_s & sel_prev_q;
	assign sel_end = sel_n_s & ~sel_prev_q;

	// datagram decode
	logic host_hit;
	logic host_write;
	logic [1:0] new_count;

	assign host_hit = (host_cnt_q == HOST_CNT_FULL)
		& ~rx_q[HOST_SPACE_BIT]
		& (rx_q[HOST_ADDR_MSB:HOST_ADDR_LSB] == CFG_ADDR);
	assign host_write = sel_end & host_hit & ~rx_q[HOST_RW_BIT];
	// a forbidden count keeps the previous one
	assign new_count = (rx_q[CFG_COUNT_LSB+:2] == COUNT_FORBIDDEN)
		? cfg_q[CFG_COUNT_LSB+:2] : rx_q[CFG_COUNT_LSB+:2];
	assign cfg_d = host_write
		? (({rx_q[23:2], new_count}) & CFG_USED_MASK) : cfg_q;

	// configuration fields
	logic [1:0] drv_count;
	logic sel_pol;
	logic clk_inv;
	logic phase_inv;
	logic decay_pol;
	logic cur_inv;
	logic per_driver;
	logic refresh;

	assign drv_count = cfg_q[CFG_COUNT_LSB+:2];
	assign sel_pol = cfg_q[CFG_SEL_POL];
	assign clk_inv = cfg_q[CFG_CLK_INV];
	assign phase_inv = cfg_q[CFG_PHASE_INV];
	assign decay_pol = cfg_q[CFG_DECAY_POL];
	assign cur_inv = cfg_q[CFG_CUR_INV];
	assign per_driver = cfg_q[CFG_PER_DRIVER];
	assign refresh = cfg_q[CFG_REFRESH];

	// per-driver datagram coding
	logic [11:0] code_mask;
	logic [FRAME_BITS-1:0] coded;
	logic [FRAME_BITS-1:0] aligned;

	assign code_mask = (phase_inv ? PHASE_MASK : 12'h000)
		| (decay_pol ? DECAY_MASK : 12'h000)
		| (cur_inv ? CUR_MASK : 12'h000);

	genvar gi;
	generate
		for (gi = 0; gi < DRIVERS; gi++) begin : g_code
			assign coded[gi*DRV_WORD_BITS+:DRV_WORD_BITS] =
				drv_word_in[gi*DRV_WORD_BITS+:DRV_WORD_BITS] ^ code_mask;
		end
	endgenerate

	// last driver first, frame left aligned
	always_comb begin
		case (drv_count)
			2'h0: aligned = coded << (2 * DRV_WORD_BITS);
			2'h1: aligned = coded << DRV_WORD_BITS;
			default: aligned = coded;
		endcase
	end

	// engine sequencing
	logic start;
	logic last_bit;
	logic in_frame;

	// with refresh off, only a demand starts a frame; waiting for busy_q
	// low keeps two idle clocks between frames
	assign start = (state_q == ST_IDLE) & ~busy_q
		& (pending_q | refresh);
	assign last_bit = (bit_q == DRV_LAST_BIT) & (seg_q == 2'h0);
	assign in_frame = (state_q == ST_SHIFT);

	always_comb begin
		case (state_q)
			ST_IDLE: state_d = start ? ST_SHIFT : ST_IDLE;
			ST_SHIFT: state_d = (clk_if.fall & last_bit) ? ST_DONE
				: ST_SHIFT;
			ST_DONE: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	assign clk_if.run = in_frame;
	assign clk_if.divider = cfg_q[CFG_DIV_LSB+:8];

	// select decode
	logic sel_common;
	logic sel_out_d;
	logic sel2_n_d;
	logic sel3_n_d;

	assign sel_common = in_frame & (~per_driver | (seg_q == 2'h0));
	assign sel_out_d = per_driver ? ~sel_common
		: (sel_pol ? sel_common : ~sel_common);
	assign sel2_n_d = ~(in_frame & per_driver & (seg_q == 2'h1));
	assign sel3_n_d = ~(in_frame & per_driver & (seg_q == 2'h2));

	// host side registers
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			sck_sync_q <= 2'b00;
			sel_sync_q <= 2'b11;
			mosi_sync_q <= 2'b00;
			sck_prev_q <= 1'b0;
			sel_prev_q <= 1'b1;
		end else begin
			sck_sync_q <= {sck_sync_q[0], host_sck_in};
			sel_sync_q <= {sel_sync_q[0], host_select_n_in};
			mosi_sync_q <= {mosi_sync_q[0], host_mosi_in};
			sck_prev_q <= sck_s;
			sel_prev_q <= sel_n_s;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			rx_q <= 32'h00000000;
			host_cnt_q <= 6'h00;
		end else if (sel_start) begin
			host_cnt_q <= 6'h00;
		end else if (sck_rise) begin
			rx_q <= {rx_q[30:0], mosi_s};
			if (host_cnt_q != HOST_CNT_MAX) begin
				host_cnt_q <= host_cnt_q + 6'h01;
			end
		end
	end

	// reply carries the current configuration
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			tx_q <= 32'h00000000;
			miso_oe_n_q <= 1'b1;
		end else begin
			miso_oe_n_q <= sel_n_s;
			if (sel_start) begin
				tx_q <= {HOST_STATUS_BYTE, cfg_q};
			end else if (sck_fall) begin
				tx_q <= {tx_q[30:0], 1'b0};
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			cfg_q <= CFG_RESET;
		end else begin
			cfg_q <= cfg_d;
		end
	end

	// demand flag: a new request wins over the clear at start
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			pending_q <= 1'b0;
		end else begin
			pending_q <= send_req_in | (pending_q & ~start);
		end
	end

	// frame shifter
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			state_q <= ST_IDLE;
			shift_q <= '0;
			seg_q <= 2'h0;
			bit_q <= 4'h0;
		end else begin
			state_q <= state_d;
			if (start) begin
				shift_q <= aligned;
				seg_q <= drv_count;
				bit_q <= 4'h0;
			end else if (in_frame && clk_if.fall) begin
				shift_q <= {shift_q[FRAME_BITS-2:0], 1'b0};
				if (bit_q == DRV_LAST_BIT) begin
					bit_q <= 4'h0;
					seg_q <= seg_q - 2'h1;
				end else begin
					bit_q <= bit_q + 4'h1;
				end
			end
		end
	end

	// registered pins
	always_ff @(posedge clk_sys_in) begin
		if (!rst_n_in) begin
			clk_out_q <= 1'b0;
			data_out_q <= 1'b0;
			sel_out_q <= 1'b1;
			sel2_n_q <= 1'b1;
			sel3_n_q <= 1'b1;
			busy_q <= 1'b0;
		end else begin
			clk_out_q <= clk_if.level ^ clk_inv;
			data_out_q <= in_frame & shift_q[FRAME_BITS-1];
			sel_out_q <= sel_out_d;
			sel2_n_q <= sel2_n_d;
			sel3_n_q <= sel3_n_d;
			busy_q <= (state_q != ST_IDLE);
		end
	end

	assign host_miso_out = tx_q[31];
	assign host_miso_oe_n_out = miso_oe_n_q;
	assign chain_clock_out = clk_out_q;
	assign chain_data_out = data_out_q;
	assign chain_select_out = sel_out_q;
	assign second_driver_select_n_out = sel2_n_q;
	assign third_driver_select_n_out = sel3_n_q;
	assign chain_busy_out = busy_q;

endmodule

// ==== verification/chain_cfg_props.sv ====
// port-level assertions for the driver chain configuration block
`timescale 1ns/10ps
module chain_cfg_props (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	input wire logic host_select_n_in,
	input wire logic host_miso_oe_n_out,
	input wire logic chain_data_out,
	input wire logic chain_busy_out,
	input wire logic second_driver_select_n_out,
	input wire logic third_driver_select_n_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	chk_idle_data_low: assert property (
		!chain_busy_out |-> !chain_data_out)
		else $error("chain data not low while idle");
	chk_selects_exclusive: assert property (
		!(!second_driver_select_n_out && !third_driver_select_n_out))
		else $error("two driver selects at once");
	chk_sel2_in_frame: assert property (
		!second_driver_select_n_out |-> chain_busy_out)
		else $error("second select outside frame");
	chk_sel3_in_frame: assert property (
		!third_driver_select_n_out |-> chain_busy_out)
		else $error("third select outside frame");
	chk_busy_min_len: assert property (
		$rose(chain_busy_out) |-> chain_busy_out[*8])
		else $error("frame too short");
	chk_frame_gap: assert property (
		$fell(chain_busy_out) |-> !chain_busy_out[*2])
		else $error("frames too close");
	chk_miso_off: assert property (host_select_n_in &&
		$past(host_select_n_in) && $past(host_select_n_in, 2) &&
		$past(host_select_n_in, 3) |=> host_miso_oe_n_out)
		else $error("reply driven without select");
	chk_miso_on: assert property (!host_select_n_in &&
		!$past(host_select_n_in) && !$past(host_select_n_in, 2) &&
		!$past(host_select_n_in, 3) |=> !host_miso_oe_n_out)
		else $error("reply not driven under select");
endmodule

// ==== verification/chain_driver_model.sv ====
// behavioural driver chain that shifts in what it is clocked
`timescale 1ns/10ps
module chain_driver_model (
	input wire logic clk_sys_in,
	input wire logic chain_clock_in,
	input wire logic chain_data_in,
	input wire logic chain_select_in,
	input wire logic sel2_n_in,
	input wire logic sel3_n_in,
	input wire logic sel_pol_in,
	input wire logic clk_inv_in,
	input wire logic per_drv_in,
	output logic [7:0] nbits_out,
	output logic [35:0] word_out,
	output logic [15:0] period_out
);
	logic sck_q = 1'b0;
	logic [15:0] t_q = 16'h0000;
	wire logic act = per_drv_in ? !(chain_select_in && sel2_n_in && sel3_n_in)
		: (chain_select_in == sel_pol_in);
	wire logic sck = chain_clock_in ^ clk_inv_in;
	initial begin
		nbits_out = 8'h00;
		word_out = 36'h0;
		period_out = 16'h0000;
	end
	// sample on the logical rising edge while selected
	always @(posedge clk_sys_in) begin
		sck_q <= sck;
		t_q <= t_q + 16'h0001;
		if (act && sck && !sck_q) begin
			word_out <= {word_out[34:0], chain_data_in};
			nbits_out <= nbits_out + 8'h01;
			period_out <= t_q + 16'h0001;
			t_q <= 16'h0000;
		end
	end
endmodule

// ==== verification/driver_chain_serial_config_tb_top.sv ====
// testbench for the driver chain configuration block
`timescale 1ns/10ps
module driver_chain_serial_config_tb_top;
	import chain_cfg_pkg::*;
	logic clk_sys_in = 0, rst_n_in = 0, host_sck_in = 0, host_mosi_in = 0;
	logic host_select_n_in = 1, send_req_in = 0, m_pol = 0, m_inv = 0, m_per = 0;
	logic [35:0] drv_word_in = 36'hA5C3E17F6;
	logic host_miso_out, host_miso_oe_n_out, chain_clock_out, chain_data_out;
	logic chain_select_out, sel2_n, sel3_n, chain_busy_out;
	logic [7:0] m_n;
	logic [35:0] m_word;
	logic [15:0] m_per_t;
	logic [7:0] n_seen;
	int fails = 0, n_checks = 0, s2 = 0, s3 = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		s2 <= s2 + int'(!sel2_n);
		s3 <= s3 + int'(!sel3_n);
	end
	driver_chain_serial_config u_driver_chain_serial_config (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.host_sck_in(host_sck_in), .host_select_n_in(host_select_n_in),
		.host_mosi_in(host_mosi_in), .host_miso_out(host_miso_out),
		.host_miso_oe_n_out(host_miso_oe_n_out), .send_req_in(send_req_in),
		.drv_word_in(drv_word_in), .chain_clock_out(chain_clock_out),
		.chain_data_out(chain_data_out), .chain_select_out(chain_select_out),
		.second_driver_select_n_out(sel2_n),
		.third_driver_select_n_out(sel3_n), .chain_busy_out(chain_busy_out));
	chain_driver_model u_chain_driver_model (.clk_sys_in(clk_sys_in),
		.chain_clock_in(chain_clock_out), .chain_data_in(chain_data_out),
		.chain_select_in(chain_select_out), .sel2_n_in(sel2_n),
		.sel3_n_in(sel3_n), .sel_pol_in(m_pol), .clk_inv_in(m_inv),
		.per_drv_in(m_per), .nbits_out(m_n), .word_out(m_word),
		.period_out(m_per_t));
	task automatic close_out();
		if (fails == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic cmp(input logic [35:0] g, input logic [35:0] e);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("ERROR %0t got %h expected %h", $time, g, e);
		end
	endtask
	// one host datagram, 5 clocks per half period
	task automatic xfer(input logic [31:0] w, output logic [31:0] r);
		r = '0;
		@(negedge clk_sys_in) host_select_n_in = 0;
		repeat (5) @(negedge clk_sys_in);
		for (int i = 31; i >= 0; i--) begin
			host_mosi_in = w[i];
			repeat (5) @(negedge clk_sys_in);
			r[i] = host_miso_out;
			host_sck_in = 1;
			repeat (5) @(negedge clk_sys_in);
			host_sck_in = 0;
		end
		repeat (5) @(negedge clk_sys_in);
		host_select_n_in = 1;
		repeat (8) @(negedge clk_sys_in);
	endtask
	task automatic wr(input logic [23:0] d);
		logic [31:0] r;
		xfer({1'b0, CFG_ADDR, 1'b0, d}, r);
	endtask
	task automatic rd(input logic [23:0] e);
		logic [31:0] r;
		xfer({1'b0, CFG_ADDR, 1'b1, 24'h000000}, r);
		cmp(36'(r), {4'h0, HOST_STATUS_BYTE, e});
	endtask
	function automatic logic [11:0] xf(logic [11:0] w, logic p, logic d,
		logic c);
		return w ^ (p ? PHASE_MASK : 12'h000) ^ (d ? DECAY_MASK : 12'h000)
			^ (c ? CUR_MASK : 12'h000);
	endfunction
	function automatic logic [35:0] fr(logic p, logic d, logic c);
		return {xf(drv_word_in[35:24], p, d, c),
			xf(drv_word_in[23:12], p, d, c), xf(drv_word_in[11:0], p, d, c)};
	endfunction
	task automatic frame(input logic [7:0] nb, input logic [35:0] e,
		input logic [15:0] per);
		logic [7:0] n0;
		n0 = m_n;
		@(negedge clk_sys_in) send_req_in = 1;
		@(negedge clk_sys_in) send_req_in = 0;
		for (int k = 0; k < 20 && chain_busy_out !== 1'b1; k++)
			@(negedge clk_sys_in);
		for (int k = 0; k < 30000 && chain_busy_out !== 1'b0; k++)
			@(negedge clk_sys_in);
		repeat (2) @(negedge clk_sys_in);
		cmp(36'(m_n - n0), 36'(nb));
		cmp(m_word & ((36'h1 << nb) - 36'h1), e);
		cmp(36'(m_per_t), 36'(per));
	endtask
	initial begin
		repeat (16) @(negedge clk_sys_in);
		rst_n_in = 1;
		rd(24'h000F00);
		repeat (100) @(negedge clk_sys_in);
		cmp(36'(chain_busy_out), 36'h0);
		cmp(36'(chain_select_out), 36'h1);
		wr(24'h000736);
		rd(24'h000736);
		m_pol = 1;
		cmp(36'(chain_select_out), 36'h0);
		frame(8'h24, fr(1, 1, 0), 16'h0010);
		wr(24'h00FF4B);
		rd(24'h00FF4A);
		m_pol = 0;
		m_inv = 1;
		cmp(36'(chain_clock_out), 36'h1);
		frame(8'h24, fr(0, 0, 1), 16'h0200);
		wr(24'h000782);
		m_inv = 0;
		m_per = 1;
		frame(8'h24, fr(0, 0, 0), 16'h0010);
		cmp(36'(s2 > 0 && s3 > 0), 36'h1);
		wr(24'h000780);
		frame(8'h0C, 36'(drv_word_in[11:0]), 16'h0010);
		// divider below the floor keeps the fastest period
		wr(24'h000380);
		frame(8'h0C, 36'(drv_word_in[11:0]), 16'h0010);
		// refresh on: frames repeat with no demand
		wr(24'h010780);
		n_seen = m_n;
		repeat (600) @(negedge clk_sys_in);
		cmp(36'(m_n - n_seen > 8'h18), 36'h1);
		wr(24'h000780);
		for (int k = 0; k < 300 && chain_busy_out !== 1'b0; k++)
			@(negedge clk_sys_in);
		n_seen = m_n;
		repeat (300) @(negedge clk_sys_in);
		cmp(36'(m_n), 36'(n_seen));
		cmp(36'(chain_busy_out), 36'h0);
		close_out();
	end
	initial begin
		repeat (80000) @(posedge clk_sys_in);
		fails++;
		close_out();
	end
endmodule
bind driver_chain_serial_config chain_cfg_props u_chain_cfg_props (
	.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.host_select_n_in(host_select_n_in),
	.host_miso_oe_n_out(host_miso_oe_n_out),
	.chain_data_out(chain_data_out), .chain_busy_out(chain_busy_out),
	.second_driver_select_n_out(second_driver_select_n_out),
	.third_driver_select_n_out(third_driver_select_n_out));
